// File: shared/flash_pkg.sv
// Behaviour
// - quad-output read accepted only with quad lines allowed; data leaves on four lines
// - quad-output read: eight dummy clocks after 24-bit address, output don't-care meanwhile
// - dual read: mode byte after address, upper nibble decides skip, lines then released
// - dual read mode nibble a: next select period skips command, address at once
// - quad read mode nibble a: next select period skips command byte, starts with address
// - other mode nibble or mode-bit reset restores normal command byte expectation
// - quad address/data read accepted only with quad lines allowed
// - wrap setting enables wrap for single-line-command quad address/data reads
// - wrapped read restarts at aligned section start until select rises
// - four-line command mode dummy count 4, 6 or 8 from two read parameters
// - dummy setting returns to 4 at reset and on reset command
// - four-line mode: mode byte counts as dummy clocks; by default two more dummy clocks follow it
// - no wrap for quad address/data read in four-line command mode
// - program only clears bits; unsent bytes of the page stay untouched
// - page program needs write latch; command, 24-bit address, data bytes on one line, on four in four-line command mode
// - program data past page end wraps; only last page of bytes remain
// - select must rise on byte boundary, else program discarded
// - self-timed program cycle with busy high, status still readable
// - write latch cleared when program busy asserts
// - quad page program needs quad lines and write latch, data on four lines
// - write latch cleared at reset and when a program completes
package flash_pkg;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_CMD    = 3'b001,
    ST_ADDR   = 3'b011,
    ST_MODE   = 3'b010,
    ST_DUMMY  = 3'b110,
    ST_DOUT   = 3'b111,
    ST_DIN    = 3'b101,
    ST_IGNORE = 3'b100
  } phase_t;

  localparam logic [7:0] CMD_QUAD_OUT  = 8'h6b;
  localparam logic [7:0] CMD_DUAL_IO   = 8'hbb;
  localparam logic [7:0] CMD_QUAD_IO   = 8'heb;
  localparam logic [7:0] CMD_PROG      = 8'h02;
  localparam logic [7:0] CMD_QUAD_PROG = 8'h33;
  localparam logic [3:0] CONT_NIBBLE   = 4'ha;

  localparam logic [5:0] CMD_BITS  = 6'h08;
  localparam logic [5:0] ADDR_BITS = 6'h18;
  localparam logic [5:0] MODE_BITS = 6'h08;
  localparam logic [5:0] BYTE_BITS = 6'h08;

  localparam logic [5:0] QOUT_DUMMY     = 6'h08;
  localparam logic [5:0] QIO_SPI_EXTRA  = 6'h04;
  localparam logic [5:0] QPI_EXTRA_4    = 6'h02;
  localparam logic [5:0] QPI_EXTRA_6    = 6'h04;
  localparam logic [5:0] QPI_EXTRA_8    = 6'h06;
  localparam logic [1:0] READ_PARAM_RST = 2'h0;
  localparam logic [7:0] WRAP_BASE      = 8'h08;

  localparam int MEM_AW       = 12;
  localparam int PAGE_AW      = 8;
  localparam int FIFO_W       = 8;
  localparam int FIFO_D       = 8;
  localparam int CLK_MHZ      = 100;
  localparam int PROG_TIME_NS = 100000;
  localparam int PROG_CYCLES  = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;
endpackage

// File: verif/flash_multi_io_bench.sv
`timescale 1ns/1ps
module flash_multi_io_bench;
  logic        i_ref_clk;
  logic        i_rst;
  logic        cs_n;
  logic        sck;
  logic [3:0]  io_in;
  logic [3:0]  io_out;
  logic [3:0]  io_oe;
  logic        quad_allow;
  logic        qpi;
  logic        wrap_en;
  logic [1:0]  wrap_len;
  logic        set_params;
  logic [1:0]  read_param;
  logic        reset_cmd;
  logic        mode_reset;
  logic        write_cmd;
  logic        busy;
  logic        latch;
  logic        cont;
  logic [31:0] q;
  int          fail_count;
  int          comparisons;
  int          extra [4] = '{2, 4, 6, 6};
  flash_multi_io #(.PROG_CYCLES(20)) flash_multi_io_i (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_sck(sck), .i_io(io_in), .o_io(io_out),
    .o_io_oe(io_oe), .i_quad_lines_allow_bit(quad_allow), .i_qpi_mode(qpi), .i_wrap_enable(wrap_en),
    .i_wrap_len(wrap_len), .i_set_read_params(set_params), .i_read_param(read_param),
    .i_reset_command(reset_cmd), .i_mode_bit_reset(mode_reset), .i_write_permit_command(write_cmd),
    .o_busy(busy), .o_write_permit_latch(latch), .o_cont_read_active(cont));
  host_model host_model_i (.i_dev_io(io_out), .i_dev_oe(io_oe), .o_cs_n(cs_n), .o_sck(sck), .o_io(io_in));
  always #5 i_ref_clk = ~i_ref_clk;
  task check(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // k picks the pulse: 8 write permit, 4 mode reset, 2 read parameters, 1 reset command
  task strobe(input logic [3:0] k);
    @(posedge i_ref_clk) {write_cmd, mode_reset, set_params, reset_cmd} <= k;
    @(posedge i_ref_clk) {write_cmd, mode_reset, set_params, reset_cmd} <= 4'h0;
    repeat (4) @(posedge i_ref_clk);
  endtask
  task wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 1000) begin
      @(posedge i_ref_clk);
      n++;
    end
    check(n < 1000, 1'b1);
  endtask
  task prog(input logic [7:0] cmd, input logic [23:0] a, input logic [31:0] d, input int n, input int w);
    host_model_i.start();
    host_model_i.send(cmd, 8, 1);
    host_model_i.send(a, 24, w);
    host_model_i.send(d, n, w);
    host_model_i.stop();
  endtask
  // cw 0 leaves the command out, as in a skipped-command frame
  task rd(input logic [7:0] cmd, input int cw, input int aw, input logic [23:0] a, input logic [7:0] mode,
          input int dc, input int dw, input int n);
    host_model_i.start();
    if (cw > 0) host_model_i.send(cmd, 8, cw);
    host_model_i.send(a, 24, aw);
    if (aw > 1) host_model_i.send(mode, 8, aw);
    if (dc > 0) host_model_i.recv(dc, 1, q);
    host_model_i.recv(n, dw, q);
    host_model_i.stop();
  endtask
  task complete_run();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #900000;
    fail_count++;
    $display("ERROR at %0t: run did not finish", $time);
    complete_run();
  end
  initial begin
    {i_ref_clk, quad_allow, qpi, wrap_en, wrap_len, set_params, read_param} = '0;
    {reset_cmd, mode_reset, write_cmd} = '0;
    i_rst = 1'b1;
    fail_count = 0;
    comparisons = 0;
    repeat (12) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    check({busy, latch, cont, io_oe}, 7'h00);
    $display("test reset done");
    prog(8'h02, 24'h0000fe, 24'h123456, 24, 1);
    check(busy, 1'b0);
    strobe(4'h8);
    check(latch, 1'b1);
    prog(8'h02, 24'h0000fe, 24'h123456, 24, 1);
    check({busy, latch}, 2'b10);
    wait_idle();
    check(latch, 1'b0);
    strobe(4'h8);
    host_model_i.start();
    host_model_i.send(8'h02, 8, 1);
    host_model_i.send(24'h000000, 24, 1);
    host_model_i.send(4'h0, 4, 1);
    host_model_i.stop();
    check(busy, 1'b0);
    @(posedge i_ref_clk) quad_allow <= 1'b1;
    prog(8'h33, 24'h000000, 8'hf0, 8, 4);
    wait_idle();
    $display("test program done");
    rd(8'h6b, 1, 1, 24'h0000fe, 8'h00, 8, 4, 16);
    check(q, 32'h1234);
    rd(8'h6b, 1, 1, 24'h000000, 8'h00, 8, 4, 8);
    check(q, 32'h50);
    @(posedge i_ref_clk) quad_allow <= 1'b0;
    rd(8'h6b, 1, 1, 24'h0000fe, 8'h00, 8, 4, 16);
    check(host_model_i.oe_seen, 1'b0);
    rd(8'heb, 1, 4, 24'h0000fe, 8'h00, 4, 4, 16);
    check(host_model_i.oe_seen, 1'b0);
    @(posedge i_ref_clk) quad_allow <= 1'b1;
    $display("test quad output read done");
    rd(8'hbb, 1, 2, 24'h0000fe, 8'ha5, 0, 2, 16);
    check({cont, q}, 33'h1_0000_1234);
    rd(8'h00, 0, 2, 24'h000000, 8'h00, 0, 2, 8);
    check({cont, q}, 33'h0_0000_0050);
    rd(8'heb, 1, 4, 24'h000000, 8'ha0, 4, 4, 8);
    check({cont, q}, 33'h1_0000_0050);
    rd(8'h00, 0, 4, 24'h0000fe, 8'ha0, 4, 4, 16);
    check(q, 32'h1234);
    strobe(4'h4);
    check(cont, 1'b0);
    $display("test continuous read done");
    @(posedge i_ref_clk) wrap_en <= 1'b1;
    rd(8'heb, 1, 4, 24'h000007, 8'h00, 4, 4, 16);
    check(q, 32'hff50);
    @(posedge i_ref_clk) qpi <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      @(posedge i_ref_clk) read_param <= 2'(p);
      strobe(4'h2);
      rd(8'heb, 4, 4, 24'h0000fe, 8'h00, extra[p], 4, 16);
      check(q, 32'h1234);
    end
    strobe(4'h1);
    rd(8'heb, 4, 4, 24'h000007, 8'h00, 2, 4, 16);
    check(q, 32'hffff);
    @(posedge i_ref_clk) qpi <= 1'b0;
    $display("test four-line mode done");
    complete_run();
  end
endmodule

// File: verif/flash_multi_io_props.sv
`timescale 1ns/1ps
module flash_multi_io_props #(
  parameter int PROG_CYCLES = 20
) (
  // clock and reset
  input wire logic       i_ref_clk,
  input wire logic       i_rst,
  // inputs
  input wire logic       i_cs_n,
  input wire logic       i_quad_lines_allow_bit,
  input wire logic       i_mode_bit_reset,
  input wire logic       i_write_permit_command,
  // outputs
  input wire logic [3:0] o_io_oe,
  input wire logic       o_busy,
  input wire logic       o_write_permit_latch,
  input wire logic       o_cont_read_active
);
  int busy_len_reg;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // length of the running busy span; a short span means the array got no program time
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !o_busy) begin
      busy_len_reg <= 0;
    end else begin
      busy_len_reg <= busy_len_reg + 1;
    end
  end
  property p_reset_quiet;
    $fell(i_rst) |-> o_io_oe == 4'h0 && !o_busy && !o_write_permit_latch && !o_cont_read_active;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not cleared by reset");
  property p_busy_clears_latch;
    $rose(o_busy) && !$past(i_write_permit_command) |-> !o_write_permit_latch;
  endproperty
  a_busy_clears_latch: assert property (p_busy_clears_latch) else $error("latch kept at busy start");
  property p_done_clears_latch;
    $fell(o_busy) && !$past(i_write_permit_command) |-> !o_write_permit_latch;
  endproperty
  a_done_clears_latch: assert property (p_done_clears_latch) else $error("latch set at busy end");
  property p_busy_after_cs;
    $rose(o_busy) |-> i_cs_n && $past(i_cs_n);
  endproperty
  a_busy_after_cs: assert property (p_busy_after_cs) else $error("busy rose inside a frame");
  property p_busy_holds;
    $rose(o_busy) |-> o_busy [*8];
  endproperty
  a_busy_holds: assert property (p_busy_holds) else $error("busy pulse too short");
  property p_busy_ends;
    $rose(o_busy) |-> ##[1:1000] !o_busy;
  endproperty
  a_busy_ends: assert property (p_busy_ends) else $error("busy never returned low");
  property p_busy_len;
    $fell(o_busy) |-> busy_len_reg >= PROG_CYCLES;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("program cycle shorter than set");
  property p_quad_needs_allow;
    o_io_oe == 4'hf |-> i_quad_lines_allow_bit;
  endproperty
  a_quad_needs_allow: assert property (p_quad_needs_allow) else $error("four lines driven while disallowed");
  property p_release_on_cs;
    $rose(i_cs_n) |-> ##[1:6] o_io_oe == 4'h0;
  endproperty
  a_release_on_cs: assert property (p_release_on_cs) else $error("lines held after deselect");
  property p_busy_no_drive;
    o_busy |-> o_io_oe == 4'h0;
  endproperty
  a_busy_no_drive: assert property (p_busy_no_drive) else $error("read served while busy");
  property p_mode_reset;
    i_mode_bit_reset && i_cs_n |-> ##[1:3] !o_cont_read_active;
  endproperty
  a_mode_reset: assert property (p_mode_reset) else $error("skip state survived mode reset");
endmodule
bind flash_multi_io flash_multi_io_props #(.PROG_CYCLES(PROG_CYCLES)) flash_multi_io_props_i (.*);

// File: verif/host_model.sv
`timescale 1ns/1ps
module host_model (
  // device outputs
  input  wire logic [3:0] i_dev_io,
  input  wire logic [3:0] i_dev_oe,
  // link pins
  output logic            o_cs_n,
  output logic            o_sck,
  output logic      [3:0] o_io
);
  logic [3:0] host_io;
  logic [3:0] host_oe;
  logic       float_bit;
  logic       oe_seen;
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    host_io = 4'h0;
    host_oe = 4'h0;
    float_bit = 1'b0;
    oe_seen = 1'b0;
  end
  // no pull on these lines: an undriven line toggles, so stale data never reads as good
  assign o_io = (i_dev_oe & i_dev_io) | (~i_dev_oe & host_oe & host_io) | (~i_dev_oe & ~host_oe & {4{float_bit}});
  always @(negedge o_sck) float_bit <= ~float_bit;
  always @(i_dev_oe) if (i_dev_oe != 4'h0) oe_seen = 1'b1;
  task start();
    oe_seen = 1'b0;
    o_cs_n = 1'b0;
    #70;
  endtask
  // only called after whole bytes, except where a broken frame is wanted
  task stop();
    #70;
    o_cs_n = 1'b1;
    host_oe = 4'h0;
    #500;
  endtask
  task automatic clk(input logic [3:0] d, input logic [3:0] oe, output logic [3:0] q);
    host_io = d;
    host_oe = oe;
    #62.5;
    o_sck = 1'b1;
    q = o_io;
    #62.5;
    o_sck = 1'b0;
  endtask
  task automatic send(input logic [31:0] v, input int n, input int w);
    logic [3:0] m;
    logic [3:0] q;
    m = 4'((1 << w) - 1);
    for (int i = n - w; i >= 0; i -= w) begin
      clk(4'(v >> i) & m, m, q);
    end
  endtask
  // every line let go from the first dummy clock on
  task automatic recv(input int n, input int w, output logic [31:0] r);
    logic [3:0] q;
    r = 32'h0;
    for (int i = 0; i < n; i += w) begin
      clk(4'h0, 4'h0, q);
      r = (r << w) | 32'(q & 4'((1 << w) - 1));
    end
  endtask
endmodule

// File: verilog/flash_multi_io.sv
`timescale 1ns/1ps
module byte_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst,
  input  wire logic         i_flush,
  // fill side
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  // drain side
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] store [0:D-1];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0]   cnt_reg;
  logic          push;
  logic          pop;

  assign o_in_ready  = cnt_reg != (AW+1)'(D);
  assign o_out_valid = cnt_reg != '0;
  assign o_out_data  = store[rd_reg];
  assign push = i_in_valid && o_in_ready;
  assign pop  = i_out_ready && o_out_valid;

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      store[wr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst || i_flush) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module flash_multi_io #(
  parameter int PROG_CYCLES = flash_pkg::PROG_CYCLES
) (
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  // serial link pins
  input  wire logic       i_cs_n,
  input  wire logic       i_sck,
  input  wire logic [3:0] i_io,
  output logic      [3:0] o_io,
  output logic      [3:0] o_io_oe,
  // configuration
  input  wire logic       i_quad_lines_allow_bit,
  input  wire logic       i_qpi_mode,
  input  wire logic       i_wrap_enable,
  input  wire logic [1:0] i_wrap_len,
  input  wire logic       i_set_read_params,
  input  wire logic [1:0] i_read_param,
  input  wire logic       i_reset_command,
  input  wire logic       i_mode_bit_reset,
  input  wire logic       i_write_permit_command,
  // status
  output logic            o_busy,
  output logic            o_write_permit_latch,
  output logic            o_cont_read_active
);
  import flash_pkg::*;

  logic [7:0] mem [0:(1<<MEM_AW)-1];
  logic [(1<<MEM_AW)-1:0] used_reg;
  logic [7:0] pbuf [0:(1<<PAGE_AW)-1];

  logic cs_s1, cs_s2, cs_s3, sck_s1, sck_s2, sck_s3;
  logic [3:0] io_s1, io_s2;
  logic sck_rise, sck_fall, cs_rise, cs_fall;

  phase_t      phase_reg;
  logic [7:0]  cmd_reg;
  logic [23:0] sh_reg;
  logic [5:0]  bcnt_reg;
  logic [5:0]  dtarget_reg;
  logic        cont_reg;
  logic [7:0]  cont_cmd_reg;
  logic [1:0]  rparam_reg;
  logic        wrap_reg;
  logic [5:0]  wmask_reg;
  logic [23:0] rd_addr_reg;
  logic        pf_reg;
  logic [7:0]  obyte_reg;
  logic [3:0]  orem_reg;
  logic [MEM_AW-1:PAGE_AW] page_reg;
  logic [7:0]   pidx_reg;
  logic [255:0] pmask_reg;
  logic         got_reg;
  logic         commit_reg;
  logic [7:0]   cidx_reg;
  logic [23:0]  timer_reg;

  logic [2:0]  w;
  logic [2:0]  aw;
  logic [2:0]  dw;
  logic [23:0] shn;
  logic [5:0]  bsum;
  logic        accept;
  logic        is_prog;
  logic [5:0]  extra;
  logic        addr_done;
  logic        mode_done;
  logic        byte_done;
  logic        prog_start;
  logic        fifo_ready, fifo_valid, fifo_pop;
  logic [7:0]  fifo_data;
  logic [7:0]  src;
  logic [23:0] rd_next;
  logic [7:0]  rd_byte;
  logic [MEM_AW-1:0] caddr;

  assign sck_rise = sck_s2 && !sck_s3;
  assign sck_fall = !sck_s2 && sck_s3;
  assign cs_rise  = cs_s2 && !cs_s3;
  assign cs_fall  = !cs_s2 && cs_s3;

  // every pin is sampled twice before any decision is taken on it
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cs_s1  <= 1'b1;
      cs_s2  <= 1'b1;
      cs_s3  <= 1'b1;
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      io_s1  <= 4'h0;
      io_s2  <= 4'h0;
    end else begin
      cs_s1  <= i_cs_n;
      cs_s2  <= cs_s1;
      cs_s3  <= cs_s2;
      sck_s1 <= i_sck;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      io_s1  <= i_io;
      io_s2  <= io_s1;
    end
  end

  always_comb begin
    is_prog = (cmd_reg == CMD_PROG) || (cmd_reg == CMD_QUAD_PROG);
    if (i_qpi_mode || cmd_reg == CMD_QUAD_IO || cmd_reg == CMD_QUAD_PROG) begin
      aw = 3'h4;
    end else if (cmd_reg == CMD_DUAL_IO) begin
      aw = 3'h2;
    end else begin
      aw = 3'h1;
    end
    if (cmd_reg == CMD_DUAL_IO) begin
      dw = 3'h2;
    end else if (cmd_reg == CMD_PROG && !i_qpi_mode) begin
      dw = 3'h1;
    end else begin
      dw = 3'h4;
    end
    case (phase_reg)
      ST_CMD:         w = i_qpi_mode ? 3'h4 : 3'h1;
      ST_ADDR,
      ST_MODE:        w = aw;
      ST_DIN:         w = dw;
      default:        w = 3'h1;
    endcase
    case (w)
      3'h2:    shn = {sh_reg[21:0], io_s2[1:0]};
      3'h4:    shn = {sh_reg[19:0], io_s2[3:0]};
      default: shn = {sh_reg[22:0], io_s2[0]};
    endcase
    bsum = bcnt_reg + {3'h0, w};
    case (shn[7:0])
      CMD_QUAD_OUT:  accept = i_quad_lines_allow_bit && !i_qpi_mode && !o_busy;
      CMD_DUAL_IO:   accept = !i_qpi_mode && !o_busy;
      CMD_QUAD_IO:   accept = i_quad_lines_allow_bit && !o_busy;
      CMD_PROG:      accept = !o_busy;
      CMD_QUAD_PROG: accept = i_quad_lines_allow_bit && !i_qpi_mode && !o_busy;
      default:       accept = 1'b0;
    endcase
    if (cmd_reg == CMD_DUAL_IO) begin
      extra = 6'h00;
    end else if (!i_qpi_mode) begin
      extra = QIO_SPI_EXTRA;
    end else begin
      case (rparam_reg)
        2'h0:    extra = QPI_EXTRA_4;
        2'h1:    extra = QPI_EXTRA_6;
        default: extra = QPI_EXTRA_8;
      endcase
    end
  end

  assign addr_done  = sck_rise && !cs_s2 && phase_reg == ST_ADDR && bsum == ADDR_BITS;
  assign mode_done  = sck_rise && !cs_s2 && phase_reg == ST_MODE && bsum == MODE_BITS;
  assign byte_done  = sck_rise && !cs_s2 && phase_reg == ST_DIN && bsum == BYTE_BITS;
  assign prog_start = cs_rise && phase_reg == ST_DIN && bcnt_reg == 6'h00 && got_reg
                      && o_write_permit_latch && !o_busy;

  // transaction sequencer, one step per rising link clock
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      phase_reg   <= ST_IDLE;
      cmd_reg     <= 8'h00;
      sh_reg      <= 24'h0;
      bcnt_reg    <= 6'h00;
      dtarget_reg <= 6'h00;
    end else if (cs_rise || cs_s2) begin
      phase_reg <= ST_IDLE;
      bcnt_reg  <= 6'h00;
    end else if (cs_fall) begin
      bcnt_reg <= 6'h00;
      if (cont_reg && !o_busy) begin
        phase_reg <= ST_ADDR;
        cmd_reg   <= cont_cmd_reg;
      end else begin
        phase_reg <= ST_CMD;
      end
    end else if (sck_rise) begin
      sh_reg   <= shn;
      bcnt_reg <= bsum;
      case (phase_reg)
        ST_CMD: begin
          if (bsum == CMD_BITS) begin
            bcnt_reg  <= 6'h00;
            cmd_reg   <= shn[7:0];
            phase_reg <= accept ? ST_ADDR : ST_IGNORE;
          end
        end
        ST_ADDR: begin
          if (bsum == ADDR_BITS) begin
            bcnt_reg <= 6'h00;
            if (is_prog) begin
              phase_reg <= ST_DIN;
            end else if (cmd_reg == CMD_QUAD_OUT) begin
              phase_reg   <= ST_DUMMY;
              dtarget_reg <= QOUT_DUMMY;
            end else begin
              phase_reg <= ST_MODE;
            end
          end
        end
        ST_MODE: begin
          if (bsum == MODE_BITS) begin
            bcnt_reg    <= 6'h00;
            dtarget_reg <= extra;
            phase_reg   <= (extra == 6'h00) ? ST_DOUT : ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          bcnt_reg <= bcnt_reg + 6'h01;
          if (bcnt_reg + 6'h01 == dtarget_reg) begin
            bcnt_reg  <= 6'h00;
            phase_reg <= ST_DOUT;
          end
        end
        ST_DIN: begin
          if (bsum == BYTE_BITS) begin
            bcnt_reg <= 6'h00;
          end
        end
        default: bcnt_reg <= 6'h00;
      endcase
    end
  end

  // skip state survives the select gap; a mode reset pattern clears it
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cont_reg     <= 1'b0;
      cont_cmd_reg <= 8'h00;
    end else if (mode_done) begin
      cont_reg     <= shn[7:4] == CONT_NIBBLE;
      cont_cmd_reg <= cmd_reg;
    end else if (i_mode_bit_reset) begin
      cont_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst || i_reset_command) begin
      rparam_reg <= READ_PARAM_RST;
    end else if (i_set_read_params) begin
      rparam_reg <= i_read_param;
    end
  end

  // read prefetch into the fifo, so the falling-edge shifter never waits on the array
  assign rd_next = wrap_reg
                 ? {rd_addr_reg[23:6], (rd_addr_reg[5:0] & ~wmask_reg) | ((rd_addr_reg[5:0] + 6'h01) & wmask_reg)}
                 : rd_addr_reg + 24'h1;
  assign rd_byte = used_reg[rd_addr_reg[MEM_AW-1:0]] ? mem[rd_addr_reg[MEM_AW-1:0]] : 8'hff;
  assign caddr   = {page_reg, cidx_reg};

  always_ff @(posedge i_ref_clk) begin
    if (i_rst || cs_rise) begin
      pf_reg      <= 1'b0;
      wrap_reg    <= 1'b0;
      wmask_reg   <= 6'h00;
      rd_addr_reg <= 24'h0;
    end else if (addr_done && !is_prog) begin
      pf_reg      <= 1'b1;
      rd_addr_reg <= shn;
      wrap_reg    <= i_wrap_enable && cmd_reg == CMD_QUAD_IO && !i_qpi_mode;
      wmask_reg   <= 6'((WRAP_BASE << i_wrap_len) - 8'h01);
    end else if (pf_reg && fifo_ready) begin
      rd_addr_reg <= rd_next;
    end
  end

  byte_fifo #(
    .W (FIFO_W),
    .D (FIFO_D)
  ) u_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_rst       (i_rst),
    .i_flush     (cs_rise || cs_fall),
    .i_in_valid  (pf_reg),
    .i_in_data   (rd_byte),
    .o_in_ready  (fifo_ready),
    .o_out_valid (fifo_valid),
    .o_out_data  (fifo_data),
    .i_out_ready (fifo_pop)
  );

  assign fifo_pop = sck_fall && phase_reg == ST_DOUT && orem_reg == 4'h0 && !cs_s2;
  assign src      = (orem_reg == 4'h0) ? (fifo_valid ? fifo_data : 8'h00) : obyte_reg;

  // data leaves on falling link clocks; dummy clocks keep lines released
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || cs_rise || cs_s2) begin
      o_io      <= 4'h0;
      o_io_oe   <= 4'h0;
      obyte_reg <= 8'h00;
      orem_reg  <= 4'h0;
    end else if (sck_fall && phase_reg == ST_DOUT) begin
      if (dw == 3'h4) begin
        o_io      <= src[7:4];
        o_io_oe   <= 4'hf;
        obyte_reg <= {src[3:0], 4'h0};
      end else begin
        o_io      <= {2'h0, src[7:6]};
        o_io_oe   <= 4'h3;
        obyte_reg <= {src[5:0], 2'h0};
      end
      orem_reg <= (orem_reg == 4'h0 ? 4'h8 : orem_reg) - {1'b0, dw};
    end
  end

  // program data collection; the index wraps inside the page by its width
  always_ff @(posedge i_ref_clk) begin
    if (byte_done) begin
      pbuf[pidx_reg] <= shn[7:0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pidx_reg  <= 8'h00;
      pmask_reg <= 256'h0;
      got_reg   <= 1'b0;
      page_reg  <= '0;
    end else if (addr_done && is_prog) begin
      pidx_reg  <= shn[7:0];
      page_reg  <= shn[MEM_AW-1:PAGE_AW];
      pmask_reg <= 256'h0;
      got_reg   <= 1'b0;
    end else if (byte_done) begin
      pidx_reg            <= pidx_reg + 8'h01;
      pmask_reg[pidx_reg] <= 1'b1;
      got_reg             <= 1'b1;
    end
  end

  // commit walks the page once, then the timer models the rest of the cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_busy     <= 1'b0;
      commit_reg <= 1'b0;
      cidx_reg   <= 8'h00;
      timer_reg  <= 24'h0;
    end else if (prog_start) begin
      o_busy     <= 1'b1;
      commit_reg <= 1'b1;
      cidx_reg   <= 8'h00;
      timer_reg  <= 24'h0;
    end else if (commit_reg) begin
      cidx_reg <= cidx_reg + 8'h01;
      if (cidx_reg == 8'hff) begin
        commit_reg <= 1'b0;
      end
    end else if (o_busy) begin
      timer_reg <= timer_reg + 24'h1;
      if (timer_reg >= 24'(PROG_CYCLES - 1)) begin
        o_busy <= 1'b0;
      end
    end
  end

  // never-programmed bytes read as erased; limitation: reset therefore erases the model array
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      used_reg <= '0;
    end else if (commit_reg && pmask_reg[cidx_reg]) begin
      used_reg[caddr] <= 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (commit_reg && pmask_reg[cidx_reg]) begin
      mem[caddr] <= (used_reg[caddr] ? mem[caddr] : 8'hff) & pbuf[cidx_reg];
    end
  end

  // a permit command in the same cycle as a clear wins
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_write_permit_latch <= 1'b0;
    end else if (i_write_permit_command) begin
      o_write_permit_latch <= 1'b1;
    end else if (prog_start) begin
      o_write_permit_latch <= 1'b0;
    end else if (o_busy && !commit_reg && timer_reg >= 24'(PROG_CYCLES - 1)) begin
      o_write_permit_latch <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_cont_read_active <= 1'b0;
    end else begin
      o_cont_read_active <= cont_reg;
    end
  end
endmodule
